/* File: uci_core.sv */
`timescale 1ns/100ps
`default_nettype none

module uci_core
#(
	parameter bit HAS_FLOW_CTRL = 1'b1,
	parameter bit HAS_SW_BAUD = 1'b1,
	parameter bit HAS_EOP_REG = 1'b1,
	parameter logic [uci_pkg::DIV_W-1:0] FIXED_DIVISOR = uci_pkg::DIVISOR_RESET
)
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [uci_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [uci_pkg::DATA_W-1:0] reg_wdata_in,
	output logic [uci_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic parity_err_in,
	input wire logic framing_err_in,
	input wire logic break_det_in,
	input wire logic rx_overrun_in,
	input wire logic tx_overrun_in,
	input wire logic shifter_empty_in,
	input wire logic tx_ready_in,
	input wire logic rx_ready_in,
	input wire logic tx_load_in,
	input wire logic [uci_pkg::CHAR_W-1:0] tx_char_in,
	input wire logic rx_take_in,
	input wire logic [uci_pkg::CHAR_W-1:0] rx_char_in,
	input wire logic tx_shift_in,
	input wire logic cts_n_in,
	output logic txd_out,
	output logic rts_n_out,
	output logic irq_out,
	output logic baud_tick_out
);

	// registered state and its next value
	uci_pkg::uci_state_t st;
	uci_pkg::uci_state_t next_st;

	// decoded accesses
	logic wr_status;
	logic wr_control;
	logic wr_divisor;
	logic wr_eop_char;
	logic ack_clear;

	// event detection
	logic tx_eop_hit;
	logic rx_eop_hit;
	logic eop_event;
	logic cts_edge;
	logic cts_level;
	logic exception;

	// assembled register images
	logic [uci_pkg::DATA_W-1:0] status_img;
	logic [uci_pkg::DATA_W-1:0] control_img;
	logic [uci_pkg::CTRL_W-1:0] ctrl_wmask;
	logic [uci_pkg::CTRL_W-1:0] flag_vec;
	logic [uci_pkg::DIV_W-1:0] active_divisor;

	// gated interrupt sources, one per status position
	logic [uci_pkg::CTRL_W-1:0] irq_src;

	// write strobes per register index
	always_comb
	begin
		wr_status = 1'b0;
		wr_control = 1'b0;
		wr_divisor = 1'b0;
		wr_eop_char = 1'b0;
		if (reg_wr_in && reg_addr_in == uci_pkg::REG_STATUS)
		begin
			wr_status = 1'b1;
		end
		else if (reg_wr_in && reg_addr_in == uci_pkg::REG_CONTROL)
		begin
			wr_control = 1'b1;
		end
		else if (reg_wr_in && reg_addr_in == uci_pkg::REG_DIVISOR)
		begin
			wr_divisor = HAS_SW_BAUD;
		end
		else if (reg_wr_in && reg_addr_in == uci_pkg::REG_EOP_CHAR)
		begin
			wr_eop_char = HAS_EOP_REG;
		end
	end

	// any status write acknowledges every sticky flag
	assign ack_clear = wr_status;

	// character compare on a tx holding write or an rx holding read
	assign tx_eop_hit = tx_load_in && (tx_char_in == st.eop_char);
	assign rx_eop_hit = rx_take_in && (rx_char_in == st.eop_char);
	assign eop_event = HAS_EOP_REG && (tx_eop_hit || rx_eop_hit);

	// cts change: compare the second sync stage with its previous value
	assign cts_edge = HAS_FLOW_CTRL && (st.cts_sync[1] != st.cts_prev);
	assign cts_level = HAS_FLOW_CTRL && !st.cts_sync[1];

	// exception is the or of the five error flags
	assign exception = st.parity | st.framing | st.brk | st.rx_overrun | st.tx_overrun;

	// rts cannot be written when flow control is not built
	always_comb
	begin
		ctrl_wmask = {uci_pkg::CTRL_W{1'b1}};
		ctrl_wmask[uci_pkg::BIT_CTS_RTS] = HAS_FLOW_CTRL;
	end

	// flag vector lined up with the enable bits
	always_comb
	begin
		flag_vec = '0;
		flag_vec[uci_pkg::BIT_PARITY] = st.parity;
		flag_vec[uci_pkg::BIT_FRAMING] = st.framing;
		flag_vec[uci_pkg::BIT_BREAK] = st.brk;
		flag_vec[uci_pkg::BIT_RX_OVERRUN] = st.rx_overrun;
		flag_vec[uci_pkg::BIT_TX_OVERRUN] = st.tx_overrun;
		flag_vec[uci_pkg::BIT_SHIFTER_EMPTY] = shifter_empty_in;
		flag_vec[uci_pkg::BIT_TX_READY] = tx_ready_in;
		flag_vec[uci_pkg::BIT_RX_READY] = rx_ready_in;
		flag_vec[uci_pkg::BIT_EXCEPTION] = exception;
		flag_vec[uci_pkg::BIT_CTS_CHANGE] = st.cts_change;
		flag_vec[uci_pkg::BIT_PACKET_END] = st.packet_end;
	end

	// per-bit interrupt sources: a flag counts only with the enable at its position;
	// the send-break and rts positions are line controls and never raise the line
	genvar gi;
	generate
		for (gi = 0; gi < uci_pkg::CTRL_W; gi = gi + 1)
		begin : g_irq_src
			if (gi == uci_pkg::BIT_SEND_BREAK || gi == uci_pkg::BIT_CTS_RTS)
			begin : g_line_ctrl
				// bit 9 drives the break, bit 11 the rts pin
				assign irq_src[gi] = 1'b0;
			end
			else
			begin : g_enabled
				assign irq_src[gi] = flag_vec[gi] & st.ctrl[gi];
			end
		end
	endgenerate

	// status read image; bit 9 is reserved and reads zero
	always_comb
	begin
		status_img = '0;
		status_img[uci_pkg::CTRL_W-1:0] = flag_vec;
		status_img[uci_pkg::BIT_CTS_RTS] = cts_level;
		status_img[uci_pkg::BIT_PACKET_END] = HAS_EOP_REG && st.packet_end;
	end

	// control read image is the stored bits, rts already masked on write
	always_comb
	begin
		control_img = '0;
		control_img[uci_pkg::CTRL_W-1:0] = st.ctrl;
	end

	// next state of everything
	always_comb
	begin
		next_st = st;

		// control register, only written by software
		if (wr_control)
		begin
			next_st.ctrl = reg_wdata_in[uci_pkg::CTRL_W-1:0] & ctrl_wmask;
		end

		// sticky flags: a set in the clearing cycle wins
		next_st.parity = parity_err_in | (st.parity & ~ack_clear);
		next_st.framing = framing_err_in | (st.framing & ~ack_clear);
		next_st.brk = break_det_in | (st.brk & ~ack_clear);
		next_st.rx_overrun = rx_overrun_in | (st.rx_overrun & ~ack_clear);
		next_st.tx_overrun = tx_overrun_in | (st.tx_overrun & ~ack_clear);
		next_st.cts_change = cts_edge | (st.cts_change & ~ack_clear);
		next_st.packet_end = eop_event | (st.packet_end & ~ack_clear);

		// two-stage synchroniser for the cts pin, then its history
		next_st.cts_sync = {st.cts_sync[0], cts_n_in};
		next_st.cts_prev = st.cts_sync[1];

		// optional divisor and end character
		if (wr_divisor)
		begin
			next_st.divisor = reg_wdata_in[uci_pkg::DIV_W-1:0];
		end
		if (wr_eop_char)
		begin
			next_st.eop_char = reg_wdata_in[uci_pkg::CHAR_W-1:0];
		end

		// registered read data; reads have no side effects here
		if (reg_rd_in)
		begin
			if (reg_addr_in == uci_pkg::REG_STATUS)
			begin
				next_st.rdata = status_img;
			end
			else if (reg_addr_in == uci_pkg::REG_CONTROL)
			begin
				next_st.rdata = control_img;
			end
			else if (reg_addr_in == uci_pkg::REG_DIVISOR && HAS_SW_BAUD)
			begin
				next_st.rdata = st.divisor;
			end
			else if (reg_addr_in == uci_pkg::REG_EOP_CHAR && HAS_EOP_REG)
			begin
				next_st.rdata = {8'h00, st.eop_char};
			end
			else
			begin
				next_st.rdata = uci_pkg::UNDEF_READ;
			end
		end

		// forced break beats the shifter's level
		next_st.txd = st.ctrl[uci_pkg::BIT_SEND_BREAK] ? 1'b0 : tx_shift_in;

		// rts pin follows only its own control bit
		next_st.rts_n = ~st.ctrl[uci_pkg::BIT_CTS_RTS];

		// level interrupt from current flags and enables
		next_st.irq = |irq_src;
	end

	// state register
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st.ctrl <= uci_pkg::CTRL_RESET;
			st.parity <= 1'b0;
			st.framing <= 1'b0;
			st.brk <= 1'b0;
			st.rx_overrun <= 1'b0;
			st.tx_overrun <= 1'b0;
			st.cts_change <= 1'b0;
			st.packet_end <= 1'b0;
			st.cts_sync <= uci_pkg::CTS_SYNC_RESET;
			st.cts_prev <= 1'b1;
			st.divisor <= uci_pkg::DIVISOR_RESET;
			st.eop_char <= uci_pkg::EOP_CHAR_RESET;
			st.rdata <= uci_pkg::RDATA_RESET;
			st.txd <= 1'b1;
			st.rts_n <= 1'b1;
			st.irq <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// the divider uses the register or the fixed build value
	assign active_divisor = HAS_SW_BAUD ? st.divisor : FIXED_DIVISOR;

	uci_baud_gen u_baud
	(
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.divisor_in(active_divisor),
		.tick_out(baud_tick_out)
	);

	// outputs straight from flip-flops
	assign reg_rdata_out = st.rdata;
	assign txd_out = st.txd;
	assign rts_n_out = st.rts_n;
	assign irq_out = st.irq;

endmodule : uci_core

`default_nettype wire

/* File: uci_pkg.sv */
// shared constants and types for the uart control, interrupt and option block
package uci_pkg;

	// register indices on the word-addressed register port
	localparam logic [2:0] REG_RXDATA = 3'h0;
	localparam logic [2:0] REG_TXDATA = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_CONTROL = 3'h3;
	localparam logic [2:0] REG_DIVISOR = 3'h4;
	localparam logic [2:0] REG_EOP_CHAR = 3'h5;

	// widths
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int CTRL_W = 13;
	localparam int CHAR_W = 8;
	localparam int DIV_W = 16;

	// status and control bit positions (an enable sits at its flag's position)
	localparam int BIT_PARITY = 0;
	localparam int BIT_FRAMING = 1;
	localparam int BIT_BREAK = 2;
	localparam int BIT_RX_OVERRUN = 3;
	localparam int BIT_TX_OVERRUN = 4;
	localparam int BIT_SHIFTER_EMPTY = 5;
	localparam int BIT_TX_READY = 6;
	localparam int BIT_RX_READY = 7;
	localparam int BIT_EXCEPTION = 8;
	localparam int BIT_SEND_BREAK = 9;
	localparam int BIT_CTS_CHANGE = 10;
	localparam int BIT_CTS_RTS = 11;
	localparam int BIT_PACKET_END = 12;

	// values after reset
	localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;
	localparam logic [CHAR_W-1:0] EOP_CHAR_RESET = 8'h00;
	localparam logic [DIV_W-1:0] DIVISOR_RESET = 16'h01b1;
	localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] UNDEF_READ = 16'h0000;
	localparam logic [1:0] CTS_SYNC_RESET = 2'h3;

	// counter state of the bit-rate divider
	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} uci_baud_state_t;

	// complete state of the control block
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic parity;
		logic framing;
		logic brk;
		logic rx_overrun;
		logic tx_overrun;
		logic cts_change;
		logic packet_end;
		logic [1:0] cts_sync;
		logic cts_prev;
		logic [DIV_W-1:0] divisor;
		logic [CHAR_W-1:0] eop_char;
		logic [DATA_W-1:0] rdata;
		logic txd;
		logic rts_n;
		logic irq;
	} uci_state_t;

endpackage : uci_pkg

/* File: uci_baud_gen.sv */
`timescale 1ns/100ps
`default_nettype none

// bit-rate tick generator: one mclk pulse every divisor+1 cycles
module uci_baud_gen
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [uci_pkg::DIV_W-1:0] divisor_in,
	output logic tick_out
);

	uci_pkg::uci_baud_state_t st;
	uci_pkg::uci_baud_state_t next_st;

	// count down from the divisor; reload and pulse at zero
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.count == '0)
		begin
			next_st.count = divisor_in;
			next_st.tick = 1'b1;
		end
		else if (st.count > divisor_in)
		begin
			next_st.count = divisor_in; // shrinking divisor takes effect at once
		end
		else
		begin
			next_st.count = st.count - 16'h0001;
		end
	end

	// state register
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st.count <= uci_pkg::DIVISOR_RESET;
			st.tick <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;

endmodule : uci_baud_gen

`default_nettype wire

/* File: uci_checker.sv */
`timescale 1ns/100ps
`default_nettype none

module uci_checker
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic [uci_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [uci_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic [uci_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic parity_err_in,
	input wire logic tx_load_in,
	input wire logic [uci_pkg::CHAR_W-1:0] tx_char_in,
	input wire logic tx_shift_in,
	input wire logic txd_out,
	input wire logic rts_n_out,
	input wire logic irq_out,
	input wire logic baud_tick_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	logic [12:0] ctrl_m;
	logic [15:0] div_m;
	logic [7:0] eop_m;

	// shadow of the writable registers, updated on the same edge as the block
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_m <= uci_pkg::CTRL_RESET;
			div_m <= uci_pkg::DIVISOR_RESET;
			eop_m <= uci_pkg::EOP_CHAR_RESET;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == uci_pkg::REG_CONTROL) ctrl_m <= reg_wdata_in[12:0];
			if (reg_addr_in == uci_pkg::REG_DIVISOR) div_m <= reg_wdata_in;
			if (reg_addr_in == uci_pkg::REG_EOP_CHAR) eop_m <= reg_wdata_in[7:0];
		end
	end

	// pins follow the control bits one cycle later
	rts_pin_a: assert property (1'b1 |-> rts_n_out == !$past(ctrl_m[11]))
		else $error("rts pin does not follow its control bit");
	txd_break_a: assert property (ctrl_m[9] |=> !txd_out)
		else $error("serial output not held low during break");
	txd_pass_a: assert property (!ctrl_m[9] |=> txd_out == $past(tx_shift_in))
		else $error("serial output does not follow the transmitter");
	// register reads
	ctrl_read_a: assert property (reg_rd_in && reg_addr_in == uci_pkg::REG_CONTROL
		|=> reg_rdata_out == {3'h0, $past(ctrl_m)}) else $error("control readback wrong");
	rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");
	// interrupt line
	irq_zero_a: assert property (ctrl_m == 13'h0000 [*2] |=> !irq_out)
		else $error("interrupt with all enables clear");
	irq_parity_a: assert property (parity_err_in && ctrl_m[0] ##1 ctrl_m[0] |=> irq_out)
		else $error("enabled parity event gave no interrupt");
	eop_irq_a: assert property (tx_load_in && tx_char_in == eop_m && ctrl_m[12]
		##1 ctrl_m[12] |=> irq_out) else $error("end character gave no interrupt");
	irq_clear_a: assert property (reg_wr_in && reg_addr_in == uci_pkg::REG_STATUS
		&& !parity_err_in && ctrl_m == 13'h0001 ##1 ctrl_m == 13'h0001 |=> !irq_out)
		else $error("interrupt did not drop after status write");
	baud_period_a: assert property (baud_tick_out && div_m == 16'h0003
		|=> !baud_tick_out [*3] ##1 baud_tick_out) else $error("baud tick period wrong");
endmodule : uci_checker

bind uci_core uci_checker i_uci_checker (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wr_in,
	.reg_rd_in, .reg_wdata_in, .reg_rdata_out, .parity_err_in, .tx_load_in, .tx_char_in,
	.tx_shift_in, .txd_out, .rts_n_out, .irq_out, .baud_tick_out);

`default_nettype wire

/* File: uci_line_model.sv */
`timescale 1ns/100ps
`default_nettype none

module uci_line_model
(
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic cts_flip_in,
	output logic tx_shift_out,
	output logic cts_n_out
);
	// transmitter level changes every cycle; clear-to-send toggles on request
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tx_shift_out <= 1'b1;
			cts_n_out <= 1'b1;
		end
		else
		begin
			tx_shift_out <= ~tx_shift_out;
			if (cts_flip_in) cts_n_out <= ~cts_n_out;
		end
	end
endmodule : uci_line_model

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic mclk_in, arst_n_in, reg_wr_in, reg_rd_in, tx_load_in, rx_take_in, cts_flip, rd_d;
	logic tx_shift, cts_n, txd_out, rts_n_out, irq_out, baud_tick_out;
	logic [2:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, rv;
	logic [7:0] ev, tx_char_in, rx_char_in, eop_c;
	logic [15:0] exp_q[$];
	int err_total, checks_done, gap;

	uci_core i_uci_core (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
		.reg_wdata_in, .reg_rdata_out, .parity_err_in(ev[0]), .framing_err_in(ev[1]),
		.break_det_in(ev[2]), .rx_overrun_in(ev[3]), .tx_overrun_in(ev[4]),
		.shifter_empty_in(ev[5]), .tx_ready_in(ev[6]), .rx_ready_in(ev[7]), .tx_load_in,
		.tx_char_in, .rx_take_in, .rx_char_in, .tx_shift_in(tx_shift), .cts_n_in(cts_n),
		.txd_out, .rts_n_out, .irq_out, .baud_tick_out);
	uci_line_model i_uci_line_model (.mclk_in, .arst_n_in, .cts_flip_in(cts_flip),
		.tx_shift_out(tx_shift), .cts_n_out(cts_n));

	// free-running clock
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : cyc

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
	endtask : rd

	task automatic clr;
		wr(uci_pkg::REG_STATUS, 16'h0000);
		cyc(2);
		chk(16'(irq_out), 16'h0000);
	endtask : clr

	task automatic xfer(input logic tx, input logic [7:0] c);
		@(posedge mclk_in);
		tx_char_in <= c;
		rx_char_in <= c;
		tx_load_in <= tx;
		rx_take_in <= !tx;
		@(posedge mclk_in);
		tx_load_in <= 1'b0;
		rx_take_in <= 1'b0;
	endtask : xfer

	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// read results are compared with the oldest noted expectation
	always @(posedge mclk_in)
	begin
		if (rd_d) chk(reg_rdata_out, exp_q.pop_front());
		rd_d <= reg_rd_in;
	end

	// cut a hang short
	initial
	begin
		#200000;
		err_total++;
		complete_run();
	end

	initial
	begin
		{reg_wr_in, reg_rd_in, tx_load_in, rx_take_in, cts_flip} = 5'h00;
		reg_addr_in = 3'h0;
		reg_wdata_in = 16'h0000;
		{ev, tx_char_in, rx_char_in} = 24'h000000;
		err_total = 0;
		checks_done = 0;
		arst_n_in = 1'b0;
		void'($urandom(9741));
		repeat (2) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		rd(uci_pkg::REG_CONTROL, 16'h0000);
		rd(uci_pkg::REG_EOP_CHAR, 16'h0000);
		rd(uci_pkg::REG_DIVISOR, uci_pkg::DIVISOR_RESET);
		rd(3'h6, uci_pkg::UNDEF_READ);
		repeat (4)
		begin
			rv = 16'($urandom) & 16'h1fff;
			wr(uci_pkg::REG_CONTROL, rv);
			rd(uci_pkg::REG_CONTROL, rv);
			rd(uci_pkg::REG_CONTROL, rv);
		end
		// each condition raises the line through its own enable
		for (int i = 0; i < 8; i++)
		begin
			wr(uci_pkg::REG_CONTROL, 16'h0001 << i);
			@(posedge mclk_in);
			ev[i] <= 1'b1;
			if (i < 5) @(posedge mclk_in);
			if (i < 5) ev[i] <= 1'b0;
			cyc(2);
			chk(16'(irq_out), 16'h0001);
			rd(uci_pkg::REG_STATUS, (16'h0001 << i) | (i < 5 ? 16'h0100 : 16'h0000));
			@(posedge mclk_in);
			ev <= 8'h00;
			clr();
		end
		wr(uci_pkg::REG_CONTROL, 16'h0100);
		xfer(1'b1, 8'h00);
		cyc(2);
		chk(16'(irq_out), 16'h0000);
		@(posedge mclk_in);
		ev[2] <= 1'b1;
		@(posedge mclk_in);
		ev[2] <= 1'b0;
		cyc(2);
		chk(16'(irq_out), 16'h0001);
		rd(uci_pkg::REG_STATUS, 16'h1104);
		clr();
		// clear-to-send change
		wr(uci_pkg::REG_CONTROL, 16'h0400);
		@(posedge mclk_in);
		cts_flip <= 1'b1;
		@(posedge mclk_in);
		cts_flip <= 1'b0;
		cyc(5);
		chk(16'(irq_out), 16'h0001);
		rd(uci_pkg::REG_STATUS, 16'h0c00);
		clr();
		rd(uci_pkg::REG_STATUS, 16'h0800);
		// end-of-packet character on both directions
		eop_c = 8'($urandom);
		wr(uci_pkg::REG_EOP_CHAR, {8'h00, eop_c});
		rd(uci_pkg::REG_EOP_CHAR, {8'h00, eop_c});
		wr(uci_pkg::REG_CONTROL, 16'h1000);
		xfer(1'b1, eop_c);
		cyc(2);
		chk(16'(irq_out), 16'h0001);
		rd(uci_pkg::REG_STATUS, 16'h1800);
		clr();
		xfer(1'b0, ~eop_c);
		rd(uci_pkg::REG_STATUS, 16'h0800);
		xfer(1'b0, eop_c);
		rd(uci_pkg::REG_STATUS, 16'h1800);
		clr();
		// break held against a toggling transmitter, then rts
		wr(uci_pkg::REG_CONTROL, 16'h0200);
		cyc(2);
		repeat (4)
		begin
			chk(16'(txd_out), 16'h0000);
			cyc(1);
		end
		wr(uci_pkg::REG_CONTROL, 16'h0800);
		cyc(2);
		chk(16'(rts_n_out), 16'h0000);
		rd(uci_pkg::REG_CONTROL, 16'h0800);
		// bit-rate tick period
		wr(uci_pkg::REG_DIVISOR, 16'h0003);
		rd(uci_pkg::REG_DIVISOR, 16'h0003);
		cyc(0); // look past the edge, not at the launching step
		gap = 0;
		while (baud_tick_out !== 1'b1 && gap < 1000)
		begin
			cyc(1);
			gap++;
		end
		gap = 0;
		cyc(1);
		while (baud_tick_out !== 1'b1 && gap < 1000)
		begin
			cyc(1);
			gap++;
		end
		chk(16'(gap + 1), 16'h0004);
		cyc(2);
		complete_run();
	end
endmodule : testbench

`default_nettype wire
